// ==== include/ebr_consts.vh ====
/*
 bus release constants: state codes, widths, function select level.
 assumes inclusion by bare name from design files.
*/
`ifndef EBR_CONSTS_VH
`define EBR_CONSTS_VH
`define EBR_ADDR_W 24
`define EBR_DATA_W 16
`define EBR_CS_W 4
`define EBR_ST_OWN 2'h0
`define EBR_ST_HIGH 2'h1
`define EBR_ST_OFF 2'h2
`define EBR_ST_REL 2'h3
`define EBR_FUNC_SEL 1'h1
`endif

// ==== design/ebr_bus_release.v ====
/*
 external bus release logic: takes the bus off the pins for an external
 master, gates register access and defers the watchdog interrupt.
 assumes all inputs synchronous to clk_in; pad logic resolves enables.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ebr_consts.vh"
// Summary of operation
// - low level on bus_request_n means an external release request
// - finish current bus cycle, then drive address, strobes, selects high
// - then turn off address, strobe, data drivers, then assert grant low
// - block internal register access while released; peripherals keep running
// - watchdog counting is untouched by release; choose timeout accordingly
// - upper byte write strobe driver off with pull-up during release
// - request and grant pins act as port pins unless function select and direction control are both set
// - watchdog runaway seen during release raises interrupt after release
module ebr_bus_release #(
   parameter ADDR_W = `EBR_ADDR_W,
   parameter DATA_W = `EBR_DATA_W,
   parameter CS_W = `EBR_CS_W
)(
   input wire clk_in,
   input wire rst_in,
   input wire bus_request_n_in,
   input wire port5_direction_ctrl_in,
   input wire port5_function_select_in,
   input wire port_grant_value_in,
   input wire cycle_busy_in,
   input wire [ADDR_W-1:0] addr_in,
   input wire rd_n_in,
   input wire wr_n_in,
   input wire upper_byte_write_n_in,
   input wire [CS_W-1:0] chip_select_n_in,
   input wire [DATA_W-1:0] data_in,
   input wire data_drive_in,
   input wire reg_access_in,
   input wire wdt_runaway_in,
   output reg [ADDR_W-1:0] addr_out,
   output reg addr_oe_n_out,
   output reg rd_n_out,
   output reg wr_n_out,
   output reg upper_byte_write_n_out,
   output reg upper_byte_write_oe_n_out,
   output reg upper_byte_pullup_out,
   output reg [CS_W-1:0] chip_select_n_out,
   output reg ctrl_oe_n_out,
   output reg [DATA_W-1:0] data_out,
   output reg data_oe_n_out,
   output reg bus_grant_n_out,
   output reg bus_released_out,
   output reg reg_access_ok_out,
   output reg watchdog_interrupt_out
);
   reg [1:0] state;
   reg [1:0] next_state;
   reg wdt_pending;
   reg next_grant_n;
   wire func_on;
   wire req;
   wire rel_next;

   assign func_on = port5_function_select_in == `EBR_FUNC_SEL &&
      port5_direction_ctrl_in == `EBR_FUNC_SEL;
   assign req = func_on && !bus_request_n_in;
   assign rel_next = next_state == `EBR_ST_REL ||
      next_state == `EBR_ST_OFF;

   always @*
   begin
      next_state = state;
      case (state)
         `EBR_ST_OWN:
            if (req && !cycle_busy_in)
               next_state = `EBR_ST_HIGH;
         `EBR_ST_HIGH:
            next_state = `EBR_ST_OFF;
         `EBR_ST_OFF:
            next_state = req ? `EBR_ST_REL : `EBR_ST_OWN;
         `EBR_ST_REL:
            if (!req)
               next_state = `EBR_ST_OWN;
         default:
            next_state = `EBR_ST_OWN;
      endcase
   end

   // state register
   always @(posedge clk_in)
   begin
      if (rst_in)
         state <= `EBR_ST_OWN;
      else
         state <= next_state;
   end

   always @(posedge clk_in)
   begin
      if (rst_in)
      begin
         wdt_pending <= 1'h0;
         watchdog_interrupt_out <= 1'h0;
      end
      else if (rel_next)
      begin
         wdt_pending <= wdt_pending | wdt_runaway_in;
         watchdog_interrupt_out <= 1'h0;
      end
      else
      begin
         wdt_pending <= 1'h0;
         watchdog_interrupt_out <= wdt_pending | wdt_runaway_in;
      end
   end

   always @(posedge clk_in)
   begin
      if (rst_in)
      begin
         addr_out <= {ADDR_W{1'h1}};
         rd_n_out <= 1'h1;
         wr_n_out <= 1'h1;
         upper_byte_write_n_out <= 1'h1;
         chip_select_n_out <= {CS_W{1'h1}};
      end
      else if (next_state != `EBR_ST_OWN)
      begin
         addr_out <= {ADDR_W{1'h1}};
         rd_n_out <= 1'h1;
         wr_n_out <= 1'h1;
         upper_byte_write_n_out <= 1'h1;
         chip_select_n_out <= {CS_W{1'h1}};
      end
      else
      begin
         addr_out <= addr_in;
         rd_n_out <= rd_n_in;
         wr_n_out <= wr_n_in;
         upper_byte_write_n_out <= upper_byte_write_n_in;
         chip_select_n_out <= chip_select_n_in;
      end
   end

   // core data, registered every cycle regardless of data_oe_n_out
   always @(posedge clk_in)
   begin
      if (rst_in)
         data_out <= {DATA_W{1'h0}};
      else
         data_out <= data_in;
   end

   always @(posedge clk_in)
   begin
      if (rst_in)
      begin
         addr_oe_n_out <= 1'h0;
         ctrl_oe_n_out <= 1'h0;
         data_oe_n_out <= 1'h1;
      end
      else
      begin
         addr_oe_n_out <= rel_next;
         ctrl_oe_n_out <= rel_next;
         data_oe_n_out <= rel_next | !data_drive_in;
      end
   end

   always @(posedge clk_in)
   begin
      if (rst_in)
      begin
         upper_byte_write_oe_n_out <= 1'h0;
         upper_byte_pullup_out <= 1'h0;
      end
      else
      begin
         upper_byte_write_oe_n_out <= rel_next;
         upper_byte_pullup_out <= rel_next;
      end
   end

   always @*
   begin
      if (next_state == `EBR_ST_REL)
         next_grant_n = 1'h0;
      else if (func_on)
         next_grant_n = 1'h1;
      else
         next_grant_n = port_grant_value_in;
   end

   always @(posedge clk_in)
   begin
      if (rst_in)
      begin
         bus_grant_n_out <= 1'h1;
         bus_released_out <= 1'h0;
      end
      else
      begin
         bus_grant_n_out <= next_grant_n;
         bus_released_out <= next_state == `EBR_ST_REL;
      end
   end

   always @(posedge clk_in)
   begin
      if (rst_in)
         reg_access_ok_out <= 1'h0;
      else
         reg_access_ok_out <= reg_access_in && next_state == `EBR_ST_OWN;
   end
   // watchdog lives outside; wdt_runaway_in is never gated here
endmodule
`default_nettype wire

// ==== verification/ebr_chk_assertions.sv ====
/* release checker on dut ports; bound from tb */
`timescale 1ns/1ps
`default_nettype none
module ebr_chk(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic bus_request_n_in,
   input wire logic port5_direction_ctrl_in,
   input wire logic port5_function_select_in,
   input wire logic addr_oe_n_out,
   input wire logic data_oe_n_out,
   input wire logic upper_byte_pullup_out,
   input wire logic [3:0] chip_select_n_out,
   input wire logic bus_grant_n_out,
   input wire logic bus_released_out,
   input wire logic reg_access_ok_out,
   input wire logic watchdog_interrupt_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   req_seen_a: assert property ($rose(bus_released_out) |->
      $past(!bus_request_n_in, 3)) else $error("grant unasked");
   lines_high_a: assert property ($rose(addr_oe_n_out) |->
      $past(&chip_select_n_out)) else $error("selects low");
   drivers_off_a: assert property (bus_released_out |->
      addr_oe_n_out && data_oe_n_out && !bus_grant_n_out) else $error("on");
   reg_block_a: assert property (bus_released_out || addr_oe_n_out |->
      !reg_access_ok_out) else $error("access open");
   pullup_on_a: assert property (bus_released_out |->
      upper_byte_pullup_out) else $error("no pull-up");
   port_mode_a: assert property (!(port5_direction_ctrl_in &&
      port5_function_select_in) |=> !bus_released_out) else $error("port");
   irq_defer_a: assert property (bus_released_out |->
      !watchdog_interrupt_out) else $error("early irq");
   bus_back_a: assert property (bus_request_n_in &&
      bus_released_out && port5_direction_ctrl_in &&
      port5_function_select_in |=> bus_grant_n_out && !addr_oe_n_out)
      else $error("not back");
   cover property ($rose(bus_released_out));
   cover property ($fell(bus_released_out));
   cover property (watchdog_interrupt_out);
endmodule
`default_nettype wire

// ==== verification/ebr_master.sv ====
/* external master; assumes grant from the dut */
`timescale 1ns/1ps
`default_nettype none
module ebr_master(
   input wire logic clk_in,
   input wire logic go_in,
   input wire logic bus_grant_n_in,
   output logic bus_request_n_out
);
   logic [3:0] cnt = 4'h0;
   initial bus_request_n_out = 1'h1;
   always @(posedge clk_in)
   begin
      cnt <= !go_in ? 4'h0 : cnt + {3'h0, !bus_grant_n_in && cnt != 4'h8};
      // low to ask, high after hold
      bus_request_n_out <= !go_in || cnt == 4'h8;
   end
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
/* bench: port rows then release walk; assumes dut, master, checker */
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk_in = 1'h0, rst_in = 1'h1, bus_request_n_in, go = 1'h0;
   logic port5_direction_ctrl_in = 1'h0, port5_function_select_in = 1'h0;
   logic port_grant_value_in = 1'h0, cycle_busy_in = 1'h0;
   logic reg_access_in = 1'h0, wdt_runaway_in = 1'h0;
   logic [23:0] pat = 24'h0, addr_out;
   logic [3:0] chip_select_n_out;
   logic [15:0] data_out;
   logic addr_oe_n_out, rd_n_out, wr_n_out, upper_byte_write_n_out;
   logic upper_byte_write_oe_n_out, upper_byte_pullup_out, ctrl_oe_n_out;
   logic data_oe_n_out, bus_grant_n_out, bus_released_out;
   logic reg_access_ok_out, watchdog_interrupt_out;
   logic [3:0] rows [6] = '{4'hD, 4'h0, 4'h3, 4'h4, 4'h7, 4'hB};
   int miscompares = 0, total_checks = 0, i;
   initial forever #5 clk_in = ~clk_in;
   ebr_master u_m(.clk_in, .go_in(go), .bus_grant_n_in(bus_grant_n_out),
      .bus_request_n_out(bus_request_n_in));
   ebr_bus_release u_dut(.*, .addr_in(pat), .rd_n_in(pat[0]),
      .wr_n_in(pat[1]), .upper_byte_write_n_in(pat[2]),
      .chip_select_n_in(pat[3:0]), .data_in(pat[15:0]),
      .data_drive_in(pat[4]));
   task chk(input string n, input logic [23:0] e, input logic [23:0] s);
      total_checks++;
      if (s !== e)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task final_report;
      if (miscompares == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task wait_grant(input logic v);
      for (i = 0; i < 40 && bus_grant_n_out !== v; i++)
         @(negedge clk_in);
      if (bus_grant_n_out !== v)
      begin
         chk("grant_wait", v, bus_grant_n_out);
         final_report;
      end
   endtask
   initial
   begin
      repeat (8) @(posedge clk_in);
      rst_in <= 1'h0;
      @(negedge clk_in);
      chk("cs", 24'hF, chip_select_n_out);
      foreach (rows[k])
      begin
         @(posedge clk_in);
         {port5_direction_ctrl_in, port5_function_select_in} <= rows[k][3:2];
         port_grant_value_in <= rows[k][1];
         go <= !(rows[k][3] && rows[k][2]);
         repeat (12) @(negedge clk_in);
         chk("grant", rows[k][0], bus_grant_n_out);
      end
      @(posedge clk_in) go <= 1'h0;
      {port5_direction_ctrl_in, port5_function_select_in} <= 2'h3;
      cycle_busy_in <= 1'h1;
      reg_access_in <= 1'h1;
      repeat (4) @(posedge clk_in);
      go <= 1'h1;
      repeat (8) @(negedge clk_in);
      chk("busy", 1'h0, addr_oe_n_out);
      @(posedge clk_in) cycle_busy_in <= 1'h0;
      wait_grant(1'h0);
      chk("off", 24'hF, {addr_oe_n_out, data_oe_n_out, ctrl_oe_n_out,
         upper_byte_write_oe_n_out});
      chk("reg_ok", 1'h0, reg_access_ok_out);
      @(posedge clk_in) wdt_runaway_in <= 1'h1;
      @(posedge clk_in) wdt_runaway_in <= 1'h0;
      pat <= 24'h5A5A5A;
      wait_grant(1'h1);
      chk("irq", 1'h1, watchdog_interrupt_out);
      @(negedge clk_in);
      chk("addr", 24'h5A5A5A, addr_out);
      chk("reg_ok", 1'h1, reg_access_ok_out);
      @(posedge clk_in) go <= 1'h0;
      @(posedge clk_in) go <= 1'h1;
      wait_grant(1'h0);
      @(posedge clk_in) rst_in <= 1'h1;
      @(posedge clk_in) rst_in <= 1'h0;
      @(negedge clk_in);
      chk("rst", 24'h9, {bus_grant_n_out, bus_released_out, addr_oe_n_out,
         data_oe_n_out});
      wait_grant(1'h0);
      wait_grant(1'h1);
      final_report;
   end
endmodule
bind ebr_bus_release ebr_chk u_chk(.*);
`default_nettype wire
